// ==== design/rx_pcs_pkg.sv ====
// Purpose: shared constants and types of the receive decode and byte order path
// Assumes: one clock, classic Wishbone register access
// Notes: offsets are byte addresses of aligned 32-bit words
package rx_pcs_pkg;

    // ==========================================================
    // widths and depths
    localparam int LANE_W = 10;
    localparam int WORD_W = 20;
    localparam int FIFO_DEPTH = 4;
    localparam int ADR_W = 8;
    localparam int CNT_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PATTERN = 8'h04;
    localparam logic [7:0] REG_PAD = 8'h08;
    localparam logic [7:0] REG_SYNC_CFG = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // ==========================================================
    // control field positions and reset values
    localparam int CTRL_DESER = 0;
    localparam int CTRL_DEC = 1;
    localparam int CTRL_USER = 2;
    localparam int CTRL_FLIP = 3;
    localparam int CTRL_DET = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h03;
    localparam logic [8:0] PATTERN_RST = 9'h1BC;
    localparam logic [8:0] PAD_RST = 9'h1F7;
    localparam logic [7:0] GOOD_RST = 8'h03;
    localparam logic [7:0] ERR_RST = 8'h04;
    localparam int CFG_ERR_POS = 8;

    // ==========================================================
    // status field positions
    localparam int ST_DONE = 0;
    localparam int ST_SYNC = 1;
    localparam int ST_OVF = 2;
    localparam int ST_CERR = 3;
    localparam int ST_DERR = 4;

    // control flag plus data of the sync code group
    localparam logic [8:0] COMMA_LANE = 9'h1BC;

    typedef enum logic {HUNT, LOCKED} sync_state_t;

endpackage : rx_pcs_pkg

// ==== design/rx_fifo_if.sv ====
// Purpose: carrier between the ordering logic and the phase compensation fifo
// Assumes: both ends on the same clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface rx_fifo_if #(parameter int WORD_W = 20);
    logic wr_valid;
    logic [WORD_W-1:0] wr_data;
    logic det_lat;
    logic flip_en;
    logic rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic overflow;
    modport src (output wr_valid, wr_data, det_lat, flip_en,
                 input rd_valid, rd_data, overflow);
    modport sink (input wr_valid, wr_data, det_lat, flip_en,
                  output rd_valid, rd_data, overflow);
endinterface : rx_fifo_if
`default_nettype wire

// ==== design/rx_phase_fifo.sv ====
// Purpose: four word phase compensation fifo with registered bypass mode
// Assumes: reader drains every cycle, no stall
// Notes: gray coded pointers, output bit flip per byte
`timescale 1ns/1ps
`default_nettype none
module rx_phase_fifo #(
    parameter int DEPTH = rx_pcs_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    rx_fifo_if.sink fi
);
    import rx_pcs_pkg::*;
    localparam int AW = $clog2(DEPTH) + 1;

    function automatic logic [AW-1:0] to_gray(input logic [AW-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    function automatic logic [WORD_W-1:0] flip(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        r = w;
        for (int l = 0; l < WORD_W / LANE_W; l++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                r[l*LANE_W+i] = w[l*LANE_W+7-i];
            end
        end
        flip = r;
    endfunction : flip

    // ==========================================================
    // storage and pointers
    logic [WORD_W-1:0] mem [DEPTH];
    logic [AW-1:0] wbin;
    logic [AW-1:0] rbin;
    logic [AW-1:0] wgray;
    logic [AW-1:0] rgray;
    wire empty = (wgray == rgray);
    wire full = (wgray == {~rgray[AW-1:AW-2], rgray[AW-3:0]});
    wire do_wr = fi.wr_valid && !full && !fi.det_lat;
    wire do_rd = !empty && !fi.det_lat;
    wire [WORD_W-1:0] head = mem[rbin[AW-2:0]];
    wire [WORD_W-1:0] next_out = fi.det_lat ? fi.wr_data : head;

    always_ff @(posedge clk_i)
    begin
        if (do_wr)
            mem[wbin[AW-2:0]] <= fi.wr_data;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wbin <= '0;
            rbin <= '0;
            wgray <= '0;
            rgray <= '0;
        end
        else if (fi.det_lat)
        begin
            rbin <= wbin;
            rgray <= wgray;
        end
        else
        begin
            if (do_wr)
            begin
                wbin <= wbin + 1'b1;
                wgray <= to_gray(wbin + 1'b1);
            end
            if (do_rd)
            begin
                rbin <= rbin + 1'b1;
                rgray <= to_gray(rbin + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fi.rd_valid <= 1'b0;
            fi.rd_data <= '0;
            fi.overflow <= 1'b0;
        end
        else
        begin
            fi.rd_valid <= fi.det_lat ? fi.wr_valid : do_rd;
            fi.rd_data <= fi.flip_en ? flip(next_out) : next_out;
            fi.overflow <= fi.wr_valid && full && !fi.det_lat;
        end
    end

    // ==========================================================
    // checks
    a_fifo_lat_two: assert property (@(posedge clk_i) disable iff (rst_i)
        do_wr && empty && !fi.det_lat && !$past(fi.det_lat)
        |=> ##1 fi.rd_valid)
        else $error("fifo word not out after two cycles");
    a_reg_lat_one: assert property (@(posedge clk_i) disable iff (rst_i)
        fi.det_lat && fi.wr_valid |=> fi.rd_valid)
        else $error("registered mode word not out after one cycle");
    a_fifo_depth_full: assert property (@(posedge clk_i) disable iff (rst_i)
        full |-> (AW'(wbin - rbin) == AW'(DEPTH)))
        else $error("fifo full at wrong fill level");
endmodule : rx_phase_fifo
`default_nettype wire

// ==== design/rx_pcs_decode_byte_order.sv ====
// Purpose: receive 8b/10b decode, sync detect, byte pairing, byte order,
//          phase fifo and bit flip, with Wishbone registers
// Assumes: code groups arrive from logic on clk_i, one per valid cycle
// Notes: code_i[9:4] is abcdei, code_i[3:0] is fghj
//
// Behaviour
// - decode one 10-bit group into 8 data bits plus control flag
// - decode with the standard 8b/10b tables and running disparity checks
// - when enabled, pack two consecutive bytes into one double-width word
// - make no assumption about which byte starts a pair after reset
// - pattern in upper byte while searching inserts the pad byte
// - with decoding bypassed pattern and pad compare as 8 bits
// - with decoding on pattern and pad are 9 bits, top is control
// - align mode: rising sync flag starts the pattern search
// - ordering done asserts when pattern found, padded or not
// - align mode: each new sync rise clears done and searches again
// - user mode: rising trigger input starts the search, done on find
// - four entry fifo carries words to the fabric side
// - fifo adds two cycles in normal mode
// - deterministic mode makes the fifo one register stage
// - fifo width set by parameter to channel width
// - flip option reverses bit order within each output byte
// - sync rises after count of sync groups, falls after count of errors
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rx_pcs_decode_byte_order #(
    parameter int WORD_W = rx_pcs_pkg::WORD_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [rx_pcs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [rx_pcs_pkg::LANE_W-1:0] code_i,
    input wire logic code_valid_i,
    input wire logic order_trig_i,
    output logic [WORD_W-1:0] data_o,
    output logic data_valid_o,
    output logic order_done_o,
    output logic sync_o,
    output logic code_err_o,
    output logic disp_err_o
);
    import rx_pcs_pkg::*;

    // ==========================================================
    // decode tables
    function automatic logic [5:0] dec6(input logic [5:0] s);
        unique case (s)
            6'h27, 6'h18: dec6 = 6'h20;
            6'h1D, 6'h22: dec6 = 6'h21;
            6'h2D, 6'h12: dec6 = 6'h22;
            6'h31: dec6 = 6'h23;
            6'h35, 6'h0A: dec6 = 6'h24;
            6'h29: dec6 = 6'h25;
            6'h19: dec6 = 6'h26;
            6'h38, 6'h07: dec6 = 6'h27;
            6'h39, 6'h06: dec6 = 6'h28;
            6'h25: dec6 = 6'h29;
            6'h15: dec6 = 6'h2A;
            6'h34: dec6 = 6'h2B;
            6'h0D: dec6 = 6'h2C;
            6'h2C: dec6 = 6'h2D;
            6'h1C: dec6 = 6'h2E;
            6'h17, 6'h28: dec6 = 6'h2F;
            6'h1B, 6'h24: dec6 = 6'h30;
            6'h23: dec6 = 6'h31;
            6'h13: dec6 = 6'h32;
            6'h32: dec6 = 6'h33;
            6'h0B: dec6 = 6'h34;
            6'h2A: dec6 = 6'h35;
            6'h1A: dec6 = 6'h36;
            6'h3A, 6'h05: dec6 = 6'h37;
            6'h33, 6'h0C: dec6 = 6'h38;
            6'h26: dec6 = 6'h39;
            6'h16: dec6 = 6'h3A;
            6'h36, 6'h09: dec6 = 6'h3B;
            6'h0E, 6'h0F, 6'h30: dec6 = 6'h3C;
            6'h2E, 6'h11: dec6 = 6'h3D;
            6'h1E, 6'h21: dec6 = 6'h3E;
            6'h2B, 6'h14: dec6 = 6'h3F;
            default: dec6 = 6'h00;
        endcase
    endfunction : dec6

    function automatic logic [3:0] dec4(input logic [3:0] f);
        unique case (f)
            4'hB, 4'h4: dec4 = 4'h8;
            4'h9: dec4 = 4'h9;
            4'h5: dec4 = 4'hA;
            4'hC, 4'h3: dec4 = 4'hB;
            4'hD, 4'h2: dec4 = 4'hC;
            4'hA: dec4 = 4'hD;
            4'h6: dec4 = 4'hE;
            4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'hF;
            default: dec4 = 4'h0;
        endcase
    endfunction : dec4

    // ==========================================================
    // registers
    logic [CTRL_W-1:0] ctrl;
    logic [8:0] pattern;
    logic [8:0] pad;
    logic [CNT_W-1:0] cfg_good;
    logic [CNT_W-1:0] cfg_err;
    logic ovf_flag;
    logic cerr_flag;
    logic derr_flag;
    logic order_done;
    logic sync;
    rx_fifo_if #(.WORD_W(WORD_W)) fi ();

    wire deser_en = ctrl[CTRL_DESER];
    wire dec_en = ctrl[CTRL_DEC];
    wire user_mode = ctrl[CTRL_USER];

    wire bus_req = wb_cyc_i && wb_stb_i;
    wire bus_wr = bus_req && wb_we_i && wb_ack_o;
    wire wr_ctrl = bus_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0];
    wire wr_pat_lo = bus_wr && (wb_adr_i == REG_PATTERN) && wb_sel_i[0];
    wire wr_pat_hi = bus_wr && (wb_adr_i == REG_PATTERN) && wb_sel_i[1];
    wire wr_pad_lo = bus_wr && (wb_adr_i == REG_PAD) && wb_sel_i[0];
    wire wr_pad_hi = bus_wr && (wb_adr_i == REG_PAD) && wb_sel_i[1];
    wire wr_cfg_lo = bus_wr && (wb_adr_i == REG_SYNC_CFG) && wb_sel_i[0];
    wire wr_cfg_hi = bus_wr && (wb_adr_i == REG_SYNC_CFG) && wb_sel_i[1];
    wire wr_stat = bus_wr && (wb_adr_i == REG_STATUS) && wb_sel_i[0];
    wire clr_ovf = wr_stat && wb_dat_i[ST_OVF];
    wire clr_cerr = wr_stat && wb_dat_i[ST_CERR];
    wire clr_derr = wr_stat && wb_dat_i[ST_DERR];

    wire [31:0] status_word = {27'h0000000, derr_flag, cerr_flag, ovf_flag,
                               sync, order_done};
    wire [31:0] rd_word =
        (wb_adr_i == REG_CTRL) ? {27'h0000000, ctrl} :
        (wb_adr_i == REG_PATTERN) ? {23'h000000, pattern} :
        (wb_adr_i == REG_PAD) ? {23'h000000, pad} :
        (wb_adr_i == REG_SYNC_CFG) ? {16'h0000, cfg_err, cfg_good} :
        (wb_adr_i == REG_STATUS) ? status_word : 32'h00000000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req && !wb_ack_o;
            wb_dat_o <= rd_word;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= CTRL_RST;
            pattern <= PATTERN_RST;
            pad <= PAD_RST;
            cfg_good <= GOOD_RST;
            cfg_err <= ERR_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= wb_dat_i[CTRL_W-1:0];
            if (wr_pat_lo)
                pattern[7:0] <= wb_dat_i[7:0];
            if (wr_pat_hi)
                pattern[8] <= wb_dat_i[8];
            if (wr_pad_lo)
                pad[7:0] <= wb_dat_i[7:0];
            if (wr_pad_hi)
                pad[8] <= wb_dat_i[8];
            if (wr_cfg_lo)
                cfg_good <= wb_dat_i[7:0];
            if (wr_cfg_hi)
                cfg_err <= wb_dat_i[15:8];
        end
    end

    // ==========================================================
    // 8b/10b decoder
    logic rd;
    wire [5:0] six = code_i[9:4];
    wire [3:0] four = code_i[3:0];
    wire [5:0] d6 = dec6(six);
    wire [3:0] four_adj = (six == 6'h30) ? ~four : four;
    wire [3:0] d4 = dec4(four_adj);
    wire k28 = (six == 6'h0F) || (six == 6'h30);
    wire x7_ctrl = (d6[4:0] == 5'h17 || d6[4:0] == 5'h1B ||
                    d6[4:0] == 5'h1D || d6[4:0] == 5'h1E) &&
                   (four == 4'h7 || four == 4'h8);
    wire is_ctrl = k28 || x7_ctrl;
    wire group_bad = !d6[5] || !d4[3];
    wire [2:0] ones6 = 3'($countones(six));
    wire [2:0] ones4 = 3'($countones(four));
    wire err6 = (ones6 == 3'h4 && rd) || (ones6 == 3'h2 && !rd) ||
                (six == 6'h38 && rd) || (six == 6'h07 && !rd);
    wire rd_mid = (ones6 == 3'h4) ? 1'b1 : (ones6 == 3'h2) ? 1'b0 : rd;
    wire err4 = (ones4 == 3'h3 && rd_mid) || (ones4 == 3'h1 && !rd_mid) ||
                (four == 4'hC && rd_mid) || (four == 4'h3 && !rd_mid);
    wire next_rd = (ones4 == 3'h3) ? 1'b1 : (ones4 == 3'h1) ? 1'b0 : rd_mid;
    wire [LANE_W-1:0] next_lane = dec_en ?
        {1'b0, is_ctrl, d4[2:0], d6[4:0]} : code_i;

    logic [LANE_W-1:0] lane;
    logic lane_valid;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd <= 1'b0;
            lane <= '0;
            lane_valid <= 1'b0;
            code_err_o <= 1'b0;
            disp_err_o <= 1'b0;
        end
        else
        begin
            lane_valid <= code_valid_i;
            code_err_o <= code_valid_i && dec_en && group_bad;
            disp_err_o <= code_valid_i && dec_en && (err6 || err4);
            if (code_valid_i)
                lane <= next_lane;
            if (code_valid_i && dec_en)
                rd <= next_rd;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cerr_flag <= 1'b0;
            derr_flag <= 1'b0;
            ovf_flag <= 1'b0;
        end
        else
        begin
            cerr_flag <= code_err_o || (cerr_flag && !clr_cerr);
            derr_flag <= disp_err_o || (derr_flag && !clr_derr);
            ovf_flag <= fi.overflow || (ovf_flag && !clr_ovf);
        end
    end

    // ==========================================================
    // sync detect on decoded groups
    sync_state_t sync_state;
    logic [CNT_W-1:0] good_cnt;
    logic [CNT_W-1:0] err_cnt;
    wire lane_err = code_err_o || disp_err_o;
    wire lane_comma = lane_valid && !lane_err && (lane[8:0] == COMMA_LANE);
    wire [CNT_W-1:0] good_inc = good_cnt + 8'h01;
    wire [CNT_W-1:0] err_inc = err_cnt + 8'h01;
    wire gain = (sync_state == HUNT) && lane_comma && (good_inc >= cfg_good);
    wire lose = (sync_state == LOCKED) && lane_valid && lane_err &&
                (err_inc >= cfg_err);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !dec_en)
        begin
            sync_state <= HUNT;
            good_cnt <= '0;
            err_cnt <= '0;
        end
        else if (lane_valid)
        begin
            unique case (sync_state)
                HUNT:
                begin
                    good_cnt <= (lane_comma && !gain) ? good_inc : '0;
                    if (gain)
                        sync_state <= LOCKED;
                end
                LOCKED:
                begin
                    err_cnt <= (lane_err && !lose) ? err_inc : '0;
                    if (lose)
                        sync_state <= HUNT;
                end
            endcase
        end
    end
    assign sync = (sync_state == LOCKED);

    // ==========================================================
    // byte deserializer and byte ordering
    function automatic logic hit(input logic [LANE_W-1:0] b,
                                 input logic [8:0] p, input logic d9);
        hit = d9 ? (b[8:0] == p) : (b[7:0] == p[7:0]);
    endfunction : hit

    logic sync_d;
    logic trig_d;
    logic searching;
    logic phase;
    logic [LANE_W-1:0] held;
    logic [WORD_W-1:0] word;
    logic word_valid;
    wire start_align = !user_mode && sync && !sync_d;
    wire start_user = user_mode && order_trig_i && !trig_d;
    wire start = start_align || start_user;
    wire pair_in = lane_valid && deser_en;
    wire lane_hit = hit(lane, pattern, dec_en);
    wire found_lo = pair_in && searching && !phase && lane_hit;
    wire found_hi = pair_in && searching && phase && lane_hit;
    wire found = found_lo || found_hi;
    wire [LANE_W-1:0] pad_lane = dec_en ? {1'b0, pad} : {2'b00, pad[7:0]};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_d <= 1'b0;
            trig_d <= 1'b0;
            searching <= 1'b0;
            order_done <= 1'b0;
        end
        else
        begin
            sync_d <= sync;
            trig_d <= order_trig_i;
            searching <= start || (searching && !found);
            order_done <= found || (order_done && !start);
        end
    end

    // pairing starts on whatever byte comes first after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !deser_en)
        begin
            phase <= 1'b0;
            held <= '0;
        end
        else if (lane_valid)
        begin
            held <= lane;
            phase <= !phase || found_hi;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            word <= '0;
            word_valid <= 1'b0;
        end
        else
        begin
            word_valid <= lane_valid && (!deser_en || phase);
            if (lane_valid && !deser_en)
                word <= {{(WORD_W-LANE_W){1'b0}}, lane};
            else if (pair_in && phase)
                word <= {found_hi ? pad_lane : lane, held};
        end
    end

    // ==========================================================
    // phase compensation fifo
    assign fi.wr_valid = word_valid;
    assign fi.wr_data = word;
    assign fi.det_lat = ctrl[CTRL_DET];
    assign fi.flip_en = ctrl[CTRL_FLIP];

    rx_phase_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .fi(fi)
    );

    assign data_o = fi.rd_data;
    assign data_valid_o = fi.rd_valid;
    assign order_done_o = order_done;
    assign sync_o = sync;

    // ==========================================================
    // checks
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_pad_insert: assert property (@(posedge clk_i) disable iff (rst_i)
        found_hi |=> word_valid && word[WORD_W-1:LANE_W] == $past(pad_lane)
        && phase)
        else $error("pad byte not inserted");
    a_pair_order: assert property (@(posedge clk_i) disable iff (rst_i)
        pair_in && phase && !found_hi
        |=> word == {$past(lane), $past(held)})
        else $error("bytes not paired in arrival order");
    a_done_on_find: assert property (@(posedge clk_i) disable iff (rst_i)
        found |=> order_done && !searching || $past(start))
        else $error("ordering done missing after pattern found");
    a_align_rerun: assert property (@(posedge clk_i) disable iff (rst_i)
        start_align && !found |=> searching && !order_done)
        else $error("sync rise did not restart ordering");
    a_sync_start: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(sync) && !user_mode |=> searching)
        else $error("search not started on sync rise");
    a_user_start: assert property (@(posedge clk_i) disable iff (rst_i)
        start_user |=> searching)
        else $error("user trigger did not start search");
    a_bad_code: assert property (@(posedge clk_i) disable iff (rst_i)
        code_valid_i && dec_en && !d6[5] |=> code_err_o && !lane[9])
        else $error("invalid group not flagged");
    a_sync_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        lose |=> !sync_o ##1 !sync_o)
        else $error("sync not dropped after error count");
endmodule : rx_pcs_decode_byte_order
`default_nettype wire

// ==== test/fabric_sink_model.sv ====
// Purpose: fabric side model, takes words, raises the ordering trigger
// Assumes: same clock as the block
// Notes: trigger follows fire_i one cycle late
`timescale 1ns/1ps
`default_nettype none
module fabric_sink_model (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [19:0] data_i,
    input wire logic valid_i,
    output logic trig_o,
    output logic [19:0] last_o
);
    initial trig_o = 1'b0;
    initial last_o = 20'h00000;
    always @(posedge clk_i)
    begin
        trig_o <= fire_i;
        if (valid_i)
            last_o <= data_i;
    end
endmodule : fabric_sink_model
`default_nettype wire

// ==== test/test_rx_pcs_decode_byte_order.sv ====
// Purpose: bench of the receive decode and byte order block
// Assumes: one clock, inputs driven at the rising edge
// Notes: commas go in pairs so disparity ends negative
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
        mismatches++; \
        $display("unexpected t=%0t got=%h exp=%h", $time, g, e); \
    end
module test_rx_pcs_decode_byte_order;
    import rx_pcs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cv = 1'b0, fire = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [9:0] code = 10'h000;
    logic ack, trig, dv, done, sync, cerr, derr;
    logic [19:0] dat, last;
    int mismatches = 0, tests_run = 0, n;
    always #4 clk_i = ~clk_i;
    rx_pcs_decode_byte_order u_rx_pcs_decode_byte_order (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .code_i(code), .code_valid_i(cv),
        .order_trig_i(trig), .data_o(dat), .data_valid_o(dv),
        .order_done_o(done), .sync_o(sync), .code_err_o(cerr),
        .disp_err_o(derr));
    fabric_sink_model u_fabric_sink_model (.clk_i(clk_i), .fire_i(fire),
        .data_i(dat), .valid_i(dv), .trig_o(trig), .last_o(last));
    task stop_test;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
            @(posedge clk_i);
        while (ack !== 1'b1 && ++n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            mismatches++;
            stop_test();
        end
    endtask : wb
    task send(input logic [9:0] c);
        @(posedge clk_i);
        code <= c;
        cv <= 1'b1;
    endtask : send
    task commas(input int pairs);
        repeat (pairs)
        begin
            send(10'h0FA);
            send(10'h305);
        end
    endtask : commas
    task wait_dv;
        n = 0;
        do
        begin
            @(posedge clk_i);
            cv <= 1'b0;
            #1;
        end
        while (dv !== 1'b1 && ++n < 40);
        n++;
        if (n >= 40)
        begin
            mismatches++;
            stop_test();
        end
    endtask : wait_dv
    task t_regs;
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK(q, {27'h0, CTRL_RST})
        wb(1'b0, REG_PAD, 32'h0);
        `CHK(q, {23'h0, PAD_RST})
        wb(1'b0, REG_SYNC_CFG, 32'h0);
        `CHK(q, {16'h0, ERR_RST, GOOD_RST})
        wb(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
    endtask : t_regs
    task t_align;
        commas(1);
        wait_dv();
        `CHK(n, 4)
        `CHK(dat, 20'h6F1BC)
        commas(4);
        wait_dv();
        `CHK(sync, 1'b1)
        `CHK(done, 1'b1)
    endtask : t_align
    task t_user;
        wb(1'b1, REG_CTRL, 32'h7);
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        `CHK(done, 1'b0)
        send(10'h274);
        commas(1);
        wait_dv();
        `CHK(dat, 20'h7DC00)
        wait_dv();
        `CHK(dat, 20'h6F1BC)
        @(posedge clk_i);
        #1;
        `CHK(last, 20'h6F1BC)
        `CHK(done, 1'b1)
    endtask : t_user
    task t_pair(input logic [31:0] ctrl, input int lat);
        wb(1'b1, REG_CTRL, ctrl);
        send(10'h155);
        send(10'h2AA);
        wait_dv();
        `CHK(n, lat)
        `CHK(dat, 20'hAA955)
    endtask : t_pair
    task t_flip;
        wb(1'b1, REG_CTRL, 32'h8);
        send(10'h2AD);
        wait_dv();
        `CHK(dat, 20'h002B5)
    endtask : t_flip
    task t_disp;
        wb(1'b1, REG_CTRL, 32'h3);
        send(10'h0FA);
        send(10'h0FA);
        @(posedge clk_i);
        cv <= 1'b0;
        #1;
        `CHK(derr, 1'b1)
        `CHK(cerr, 1'b0)
        wait_dv();
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(q[4], 1'b1)
        wb(1'b1, REG_STATUS, 32'h10);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(q[4], 1'b0)
    endtask : t_disp
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_align();
        t_user();
        t_pair(32'h01, 4);
        t_pair(32'h11, 3);
        t_flip();
        t_disp();
        stop_test();
    end
endmodule : test_rx_pcs_decode_byte_order
`default_nettype wire
